// >>> hw/sadc_pkg.sv
// constants, state type and helpers for the sar converter control block
//
// Overview of operation
// - successive approximation turns held level into 8 bits
// - two-bit channel field, bits 4..3, picks input
// - reference is supply rail or external reference pin
// - conversion keeps running while core sleeps on the rc clock only
// - result, control and pin config registers visible
// - control register holds clock, channel, go, flag, power
// - pin config sets each pin analog or digital
// - channel three pin may serve as reference
// - reset clears every implemented control bit
// - unimplemented control bits ignore writes, read zero
// - completion loads result, clears go, sets flag
// - conversion lasts nine and a half bit periods
// - clock codes give 2, 8, 32 tosc or rc
// - two bit periods with hold switch open after
package sadc_pkg;

    // ****************************************************************
    // register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [5:0] SADC_IDX_CTRL = 6'h08;
    localparam logic [5:0] SADC_IDX_CTRL_ALT = 6'h1F;
    localparam logic [5:0] SADC_IDX_RESULT = 6'h09;
    localparam logic [5:0] SADC_IDX_PINCFG = 6'h0A;
    localparam logic [5:0] SADC_IDX_IRQ_STAT = 6'h0B;
    localparam logic [5:0] SADC_IDX_IRQ_MASK = 6'h0C;

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int SADC_CS_LSB = 6;
    localparam int SADC_CH_LSB = 3;
    localparam int SADC_GO_BIT = 2;
    localparam int SADC_DONE_BIT = 1;
    localparam int SADC_PWR_BIT = 0;
    localparam int SADC_REF_EXT_BIT = 4;
    localparam int SADC_IRQ_DONE = 0;
    localparam int SADC_IRQ_REJECT = 1;
    localparam logic [7:0] SADC_CTRL_IMPL_MASK = 8'hDF;
    localparam logic [7:0] SADC_CTRL_RESET = 8'h00;
    localparam logic [7:0] SADC_RESULT_RESET = 8'h00;
    localparam logic [4:0] SADC_PINCFG_RESET = 5'h00;
    localparam logic [1:0] SADC_IRQ_RESET = 2'h0;

    // ****************************************************************
    // conversion clock codes and timing in half bit periods
    // ****************************************************************
    localparam logic [1:0] SADC_CLK_OSC2 = 2'h0;
    localparam logic [1:0] SADC_CLK_OSC8 = 2'h1;
    localparam logic [1:0] SADC_CLK_OSC32 = 2'h2;
    localparam logic [1:0] SADC_CLK_RC = 2'h3;
    localparam int SADC_TOSC_PER_TAD_0 = 2;
    localparam int SADC_TOSC_PER_TAD_1 = 8;
    localparam int SADC_TOSC_PER_TAD_2 = 32;
    localparam logic [4:0] SADC_CONV_HALF_TADS = 5'd19;
    localparam logic [4:0] SADC_FIRST_TRIAL_HALF = 5'd2;
    localparam logic [4:0] SADC_HOLDOFF_HALF_TADS = 5'd4;
    localparam logic [7:0] SADC_MSB_TRIAL = 8'h80;

    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_CONV = 2'b01,
        SADC_HOLDOFF = 2'b10
    } sadc_state_t;

    // clock cycles in half a bit period for the oscillator codes
    function automatic logic [4:0] sadc_half_cycles(input logic [1:0] sel);
        logic [4:0] r;
        r = 5'(SADC_TOSC_PER_TAD_0 / 2);
        if (sel == SADC_CLK_OSC8)
            r = 5'(SADC_TOSC_PER_TAD_1 / 2);
        else if (sel == SADC_CLK_OSC32)
            r = 5'(SADC_TOSC_PER_TAD_2 / 2);
        return r;
    endfunction

    // control register as software sees it
    function automatic logic [31:0] sadc_ctrl_view(input logic [7:0] ctrl);
        return {24'h000000, ctrl & SADC_CTRL_IMPL_MASK};
    endfunction

endpackage

// >>> hw/sadc_tad_gen.sv
// half bit period tick generator for the conversion clock
module sadc_tad_gen
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic sleep,
    input wire logic [1:0] clk_sel,
    input wire logic rc_half_tick,
    output logic half_tick
);

    logic [4:0] cnt;
    wire use_rc = (clk_sel == SADC_CLK_RC);
    // oscillator stops in sleep, only the rc source keeps ticking
    wire osc_run = run & ~use_rc & ~sleep;
    wire [4:0] limit = sadc_half_cycles(clk_sel) - 5'd1;
    wire wrap = osc_run & (cnt == limit);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 5'h00;
            half_tick <= 1'b0;
        end
        else
        begin
            cnt <= (!osc_run || wrap) ? 5'h00 : cnt + 5'd1;
            half_tick <= use_rc ? (run & rc_half_tick) : wrap;
        end
    end

endmodule

// >>> hw/sadc_top.sv
// sar converter control sequencer with avalon register slave
//
// Added by the designer: the Avalon-MM slave port.
module sadc_top
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    input wire logic sleep,
    input wire logic rc_half_tick,
    input wire logic cmp_in,
    output logic [7:0] dac_code,
    output logic [1:0] channel_sel,
    output logic ref_ext,
    output logic sample_en,
    output logic analog_power,
    output logic [3:0] pin_analog_en
);

    // ****************************************************************
    // state
    // ****************************************************************
    sadc_state_t state;
    sadc_state_t next_state;
    logic [1:0] clk_sel;
    logic go;
    logic done_flag;
    logic spare_bit5;
    logic [7:0] result;
    logic [7:0] trial_mask;
    logic [4:0] cnt;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic half_tick;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire [5:0] idx = address[7:2];
    wire acc_wr = write & ~waitrequest & byteenable[0];
    wire hit_ctrl = (idx == SADC_IDX_CTRL) | (idx == SADC_IDX_CTRL_ALT);
    wire hit_res = (idx == SADC_IDX_RESULT);
    wire hit_pin = (idx == SADC_IDX_PINCFG);
    wire hit_stat = (idx == SADC_IDX_IRQ_STAT);
    wire hit_mask = (idx == SADC_IDX_IRQ_MASK);
    wire ctrl_wr = acc_wr & hit_ctrl;
    wire [7:0] wd = writedata[7:0];
    wire [7:0] ctrl = {clk_sel, spare_bit5, channel_sel, go, done_flag, analog_power};
    wire [31:0] rd_mux = hit_ctrl ? sadc_ctrl_view(ctrl) :
                         hit_res ? {24'h000000, result} :
                         hit_pin ? {27'h0000000, ref_ext, pin_analog_en} :
                         hit_stat ? {30'h0, irq_stat} :
                         hit_mask ? {30'h0, irq_mask} : 32'h00000000;

    // ****************************************************************
    // control decisions
    // ****************************************************************
    wire next_power = ctrl_wr ? wd[SADC_PWR_BIT] : analog_power;
    wire start_req = ctrl_wr & wd[SADC_GO_BIT] & wd[SADC_PWR_BIT];
    wire start_reject = ctrl_wr & wd[SADC_GO_BIT] & ~wd[SADC_PWR_BIT];
    wire in_conv = (state == SADC_CONV);
    wire in_hold = (state == SADC_HOLDOFF);
    wire conv_tick = in_conv & half_tick;
    wire finish = conv_tick & (cnt == SADC_CONV_HALF_TADS - 5'd1);
    wire first_trial = conv_tick & (cnt == SADC_FIRST_TRIAL_HALF);
    wire compare = conv_tick & cnt[0] & (cnt > SADC_FIRST_TRIAL_HALF);
    wire hold_end = in_hold & half_tick & (cnt == SADC_HOLDOFF_HALF_TADS - 5'd1);
    wire [7:0] kept = cmp_in ? dac_code : (dac_code & ~trial_mask);
    wire [1:0] irq_evt = {start_reject, finish};
    wire [1:0] next_irq_stat = irq_evt | (irq_stat & ~((acc_wr & hit_stat) ? wd[1:0] : 2'h0));
    wire [1:0] next_irq_mask = (acc_wr & hit_mask) ? wd[1:0] : irq_mask;
    // hardware set of done wins over a clearing write
    wire next_done = finish | (ctrl_wr ? wd[SADC_DONE_BIT] : done_flag);
    wire next_go = !next_power ? 1'b0 : (start_req | (go & ~finish));

    always_comb
    begin
        next_state = state;
        if (!next_power)
            next_state = SADC_IDLE;
        else
        begin
            case (state)
                SADC_IDLE:
                    if (go)
                        next_state = SADC_CONV;
                SADC_CONV:
                    if (finish)
                        next_state = SADC_HOLDOFF;
                SADC_HOLDOFF:
                    if (hold_end)
                        next_state = SADC_IDLE;
                default:
                    next_state = SADC_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // bit period ticks
    // ****************************************************************
    // clock code picks the per-bit period
    sadc_tad_gen u_tad
    (
        .clk(clk),
        .reset_n(reset_n),
        .run(in_conv | in_hold),
        .sleep(sleep),
        .clk_sel(clk_sel),
        .rc_half_tick(rc_half_tick),
        .half_tick(half_tick)
    );

    // ****************************************************************
    // bus slave, one wait state per access
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end
        else
        begin
            waitrequest <= ~((read | write) & waitrequest);
            if (read & waitrequest)
                readdata <= rd_mux;
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    // all control bits clear on reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_sel <= SADC_CTRL_RESET[7:6];
            spare_bit5 <= SADC_CTRL_RESET[5];
            channel_sel <= SADC_CTRL_RESET[4:3];
            go <= SADC_CTRL_RESET[2];
            done_flag <= SADC_CTRL_RESET[1];
            analog_power <= SADC_CTRL_RESET[0];
        end
        else
        begin
            // bit five never takes a write
            spare_bit5 <= 1'b0;
            if (ctrl_wr)
            begin
                clk_sel <= wd[SADC_CS_LSB +: 2];
                channel_sel <= wd[SADC_CH_LSB +: 2];
            end
            go <= next_go;
            done_flag <= next_done;
            analog_power <= next_power;
        end
    end

    // ****************************************************************
    // pin configuration, result and interrupt registers
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_analog_en <= SADC_PINCFG_RESET[3:0];
            ref_ext <= SADC_PINCFG_RESET[SADC_REF_EXT_BIT];
            result <= SADC_RESULT_RESET;
            irq_stat <= SADC_IRQ_RESET;
            irq_mask <= SADC_IRQ_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (acc_wr & hit_pin)
            begin
                pin_analog_en <= wd[3:0];
                ref_ext <= wd[SADC_REF_EXT_BIT];
            end
            if (finish)
                result <= kept;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ****************************************************************
    // sequencer and successive approximation
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= SADC_IDLE;
            cnt <= 5'h00;
            dac_code <= 8'h00;
            trial_mask <= 8'h00;
            sample_en <= 1'b0;
        end
        else
        begin
            state <= next_state;
            // count half bit periods of the sequence
            if (next_state != state)
                cnt <= 5'h00;
            else if (half_tick)
                cnt <= cnt + 5'd1;
            // msb first trial then one bit per period
            if (first_trial)
            begin
                dac_code <= SADC_MSB_TRIAL;
                trial_mask <= SADC_MSB_TRIAL;
            end
            else if (compare)
            begin
                dac_code <= kept | (trial_mask >> 1);
                trial_mask <= trial_mask >> 1;
            end
            // hold switch open during conversion and holdoff
            sample_en <= next_power & (next_state == SADC_IDLE);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_conv_start;
        state == SADC_IDLE && go && analog_power && !ctrl_wr;
    endsequence

    sequence s_finish;
        finish;
    endsequence

    // accepted go reads back and starts
    a_go_starts_conv: assert property (s_conv_start |=> in_conv && go)
        else $error("go did not start a conversion");

    // finish on the nineteenth half period
    a_conv_length: assert property (finish |-> cnt == 5'd18 && half_tick)
        else $error("conversion length wrong");

    // result, go and flag change together
    a_done_together: assert property (s_finish |=> done_flag && !go && result == dac_code)
        else $error("completion effects not together");

    a_holdoff_open: assert property (s_finish ##0 next_power |=> in_hold && !sample_en)
        else $error("hold switch closed too early");

    // holdoff ends only after four half periods
    a_holdoff_length: assert property (in_hold && !hold_end && analog_power |=> !sample_en)
        else $error("holdoff cut short");

    // power off clears go and idles
    a_power_off: assert property (!analog_power |-> !go && state == SADC_IDLE)
        else $error("converter active without power");

    a_reserved_zero: assert property (read && !waitrequest && hit_ctrl |-> readdata[31:5] == 27'h0 || readdata[31:8] == 24'h0 && !readdata[5])
        else $error("reserved bits read nonzero");

    // channel field follows a control write
    a_channel_follow: assert property (ctrl_wr |=> channel_sel == $past(writedata[4:3]))
        else $error("channel select not updated");

    a_ref_select: assert property (acc_wr && hit_pin |=> ref_ext == $past(writedata[4]))
        else $error("reference select not updated");

    // in sleep only the rc source ticks
    a_sleep_rc: assert property (sleep && clk_sel != SADC_CLK_RC |=> !half_tick)
        else $error("oscillator tick during sleep");

    a_sar_first: assert property (first_trial |=> dac_code == 8'h80 && trial_mask == 8'h80)
        else $error("first trial wrong");

    a_irq_level: assert property (##1 irq == |(irq_stat & irq_mask))
        else $error("interrupt level mismatch");

endmodule

// >>> sim/sadc_testbench.sv
// self-checking bench for the sar converter control block
module testbench import sadc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // signals and register byte addresses
    // ****************************************************************
    localparam logic [7:0] A_CTRL = {SADC_IDX_CTRL, 2'h0};
    localparam logic [7:0] A_ALT = {SADC_IDX_CTRL_ALT, 2'h0};
    localparam logic [7:0] A_RES = {SADC_IDX_RESULT, 2'h0};
    localparam logic [7:0] A_PIN = {SADC_IDX_PINCFG, 2'h0};
    localparam logic [7:0] A_STAT = {SADC_IDX_IRQ_STAT, 2'h0};
    localparam logic [7:0] A_MASK = {SADC_IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] A_NONE = 8'h3C;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic sleep = 1'b0;
    logic rc_half_tick = 1'b0;
    logic cmp_in;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic [7:0] dac_code;
    logic [1:0] channel_sel;
    logic ref_ext;
    logic sample_en;
    logic analog_power;
    logic [3:0] pin_analog_en;
    logic [7:0] target = 8'h00;
    logic [1:0] rc_cnt = 2'h0;
    logic [1:0] c;
    logic [7:0] addrs [7];
    logic [31:0] d;
    int n_fail = 0;
    int samples_checked = 0;
    int run_cnt = 0;
    int last_run = 0;
    int h;
    int i;

    always #2.5 clk = ~clk;

    // comparator of the analog side: high while held level >= trial code
    assign cmp_in = (target >= dac_code);

    // rc conversion clock: one half period every three clocks
    always @(posedge clk)
    begin
        rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
        rc_half_tick <= (rc_cnt == 2'h2);
    end

    // length of each stretch with the hold switch open while powered
    always @(posedge clk)
    begin
        if (sample_en === 1'b0 && analog_power === 1'b1)
            run_cnt <= run_cnt + 1;
        else if (run_cnt != 0)
        begin
            last_run <= run_cnt;
            run_cnt <= 0;
        end
    end

    sadc_top u_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .sleep(sleep),
        .rc_half_tick(rc_half_tick), .cmp_in(cmp_in), .dac_code(dac_code),
        .channel_sel(channel_sel), .ref_ext(ref_ext), .sample_en(sample_en),
        .analog_power(analog_power), .pin_analog_en(pin_analog_en));

    // ****************************************************************
    // verdict, compares and bus tasks
    // ****************************************************************
    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask

    // request held until waitrequest is sampled low, then released
    task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rd);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= wd;
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        if (k == 50)
            timeout();
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] x;
        bus_cycle(a, 1'b1, {24'h0, v}, 4'hF, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] x;
        bus_cycle(a, 1'b0, 32'h0, 4'hF, x);
        chk_reg(x, {24'h0, v});
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        addrs = '{A_CTRL, A_ALT, A_RES, A_PIN, A_STAT, A_MASK, A_NONE};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        foreach (addrs[j])
            rd_chk(addrs[j], 8'h00);
        wr(A_CTRL, 8'hF9);
        rd_chk(A_CTRL, 8'hD9);
        rd_chk(A_ALT, 8'hD9);
        chk_pin({6'h0, channel_sel}, 8'h03);
        chk_pin({7'h0, analog_power}, 8'h01);
        wr(A_NONE, 8'hFF);
        rd_chk(A_NONE, 8'h00);
        wr(A_ALT, 8'h00);
        rd_chk(A_CTRL, 8'h00);
        chk_pin({7'h0, analog_power}, 8'h00);
        wr(A_PIN, 8'h1F);
        rd_chk(A_PIN, 8'h1F);
        chk_pin({4'h0, pin_analog_en}, 8'h0F);
        chk_pin({7'h0, ref_ext}, 8'h01);
        bus_cycle(A_PIN, 1'b1, 32'h0, 4'hE, d);
        rd_chk(A_PIN, 8'h1F);
        wr(A_PIN, 8'h05);
        rd_chk(A_PIN, 8'h05);
        chk_pin({7'h0, ref_ext}, 8'h00);
        chk_pin({4'h0, pin_analog_en}, 8'h05);
        wr(A_CTRL, 8'h04);
        rd_chk(A_CTRL, 8'h00);
        rd_chk(A_STAT, 8'h02);
        wr(A_STAT, 8'h02);
        rd_chk(A_STAT, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            c = 2'(k);
            h = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 16 : 3;
            target = (k == 0) ? 8'hA5 : (k == 1) ? 8'h00 : (k == 2) ? 8'hFF : 8'h3C;
            // core put to sleep just before the rc clock is chosen
            sleep <= (k == 3);
            wr(A_CTRL, {c, 1'b0, c, 3'h5});
            rd_chk(A_CTRL, {c, 1'b0, c, 3'h5});
            for (i = 0; i < 400; i++)
            begin
                bus_cycle(A_CTRL, 1'b0, 32'h0, 4'hF, d);
                if (d[SADC_GO_BIT] === 1'b0)
                    break;
            end
            if (i == 400)
                timeout();
            rd_chk(A_RES, target);
            rd_chk(A_CTRL, {c, 1'b0, c, 3'h3});
            chk_pin({6'h0, channel_sel}, {6'h0, c});
            for (i = 0; i < 200; i++)
            begin
                @(posedge clk);
                if (sample_en === 1'b1)
                    break;
            end
            if (i == 200)
                timeout();
            @(posedge clk);
            chk_pin({7'h0, last_run >= 22 * h && last_run <= 25 * h + 4}, 8'h01);
            sleep <= 1'b0;
            wr(A_CTRL, 8'h01);
            rd_chk(A_CTRL, 8'h01);
        end
        rd_chk(A_STAT, 8'h01);
        chk_pin({7'h0, irq}, 8'h00);
        wr(A_MASK, 8'h01);
        rd_chk(A_MASK, 8'h01);
        chk_pin({7'h0, irq}, 8'h01);
        wr(A_STAT, 8'h01);
        rd_chk(A_STAT, 8'h00);
        chk_pin({7'h0, irq}, 8'h00);
        wr(A_CTRL, 8'h00);
        rd_chk(A_CTRL, 8'h00);
        chk_pin({7'h0, analog_power}, 8'h00);
        wrap_up();
    end
endmodule
